/* File: hdl/lbss_defs.svh */
// constants for the local button scale setup block
`ifndef LBSS_DEFS_SVH
`define LBSS_DEFS_SVH
`define LBSS_CLK_HZ 64'd25000000
`define LBSS_IDLE_TIMEOUT_S 64'd120
`define LBSS_SET_HOLD_S 64'd2
`define LBSS_UNLOCK_HOLD_S 64'd5
`define LBSS_MODE_MEASURE 4'h0
`define LBSS_MODE_START 4'h2
`define LBSS_MODE_FULL 4'h3
`define LBSS_MODE_LAST 4'he
`define LBSS_CUR_ZERO_UA 40'sh0000000fa0
`define LBSS_CUR_SPAN_UA 40'sh0000003e80
`define LBSS_CUR_MIN_UA 40'sh0000000e10
`define LBSS_CUR_MAX_UA 40'sh0000005208
`define LBSS_CUR_STEP_UA 16'h000a
`define LBSS_LIMIT_MARGIN_DIV 40'sh0000000005
`define LBSS_TURNDOWN_DIV 40'sh0000000064
`define LBSS_START_RST 16'h0000
`define LBSS_FULL_RST 16'h3e80
`define LBSS_CUR_RST 16'h0fa0
`endif

/* File: hdl/lbss_pkg.sv */
// types shared by the local button scale setup block
package lbss_pkg;
    typedef struct packed {
        logic mode;
        logic up;
        logic down;
    } lbss_keys_type;

    typedef struct packed {
        logic signed [15:0] lower;
        logic signed [15:0] upper;
    } lbss_limits_type;

    typedef enum logic [1:0] {
        LBSS_ST_SHOW = 2'b00,
        LBSS_ST_SET = 2'b01,
        LBSS_ST_ADJUST = 2'b10
    } lbss_state_type;
endpackage

/* File: hdl/lbss_top.sv */
// local three-button operating logic with start/full scale setup
// Summary of operation
// - mode button steps to next mode
// - arrows step the output current in modes 2,3 only
// - mode press while editing stores, advances
// - two idle minutes store and show measurement
// - locked keypad ignores parameter changes
// - default state shows measured value
// - modes 2,3 only in pressure mode
// - mode 2 two-arrow hold sets start
// - mode 3 two-arrow hold sets full
// - current is linear between start and full
// - out-of-limit setting rejected, old value kept
// - live current clamped within 3600..21000 uA, adjusted current is not
// - arrows shift current, derive scale value
// - falling characteristic accepted
// - span down to one hundredth allowed
// - mode held over 5 s unlocks
`include "lbss_defs.svh"

module lbss_top
    import lbss_pkg::*;
#(
    parameter logic [31:0] IDLE_CYC = 32'(`LBSS_IDLE_TIMEOUT_S * `LBSS_CLK_HZ),
    parameter logic [31:0] SET_HOLD_CYC = 32'(`LBSS_SET_HOLD_S * `LBSS_CLK_HZ),
    parameter logic [31:0] UNLOCK_CYC = 32'(`LBSS_UNLOCK_HOLD_S * `LBSS_CLK_HZ)
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire lbss_keys_type keys_pin,
    input wire logic signed [15:0] pressure,
    input wire lbss_limits_type limits,
    input wire logic pressure_mode,
    input wire logic lock_request,
    output logic [3:0] mode_display,
    output logic signed [15:0] value_display,
    output logic [15:0] out_current,
    output logic signed [15:0] start_of_scale,
    output logic signed [15:0] full_scale,
    output logic key_locked,
    output logic editing
);

////////////////////////////////////////////////////////////////////////////////
// key synchronisers and edges

lbss_keys_type key_meta;
lbss_keys_type key_sync;
lbss_keys_type key_prev;
lbss_keys_type key_rise;

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        key_meta <= '0;
        key_sync <= '0;
        key_prev <= '0;
    end else begin
        key_meta <= keys_pin;
        key_sync <= key_meta;
        key_prev <= key_sync;
    end
end

assign key_rise = key_sync & ~key_prev;

logic any_key;
logic both_arrows;
assign any_key = key_sync.mode | key_sync.up | key_sync.down;
assign both_arrows = key_sync.up & key_sync.down;

////////////////////////////////////////////////////////////////////////////////
// timers

logic [31:0] idle_cnt;
logic [31:0] hold_cnt;
logic [31:0] mode_hold_cnt;
logic idle_expired;
logic set_hold_done;

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        idle_cnt <= '0;
    end else if (any_key || mode_display == `LBSS_MODE_MEASURE) begin
        idle_cnt <= '0;
    end else if (idle_cnt != IDLE_CYC) begin
        idle_cnt <= idle_cnt + 32'h0000_0001;
    end
end

assign idle_expired = (idle_cnt == IDLE_CYC);

// held count stops one past the limit so the hold acts once per press
always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        hold_cnt <= '0;
    end else if (!both_arrows) begin
        hold_cnt <= '0;
    end else if (hold_cnt <= SET_HOLD_CYC) begin
        hold_cnt <= hold_cnt + 32'h0000_0001;
    end
end

assign set_hold_done = (hold_cnt == SET_HOLD_CYC);

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        mode_hold_cnt <= '0;
    end else if (!key_sync.mode) begin
        mode_hold_cnt <= '0;
    end else if (mode_hold_cnt <= UNLOCK_CYC) begin
        mode_hold_cnt <= mode_hold_cnt + 32'h0000_0001;
    end
end

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        key_locked <= 1'b0;
    end else if (mode_hold_cnt == UNLOCK_CYC) begin
        key_locked <= 1'b0;
    end else if (lock_request) begin
        key_locked <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode stepping

function automatic logic [3:0] step_mode(input logic [3:0] m, input logic pm);
    logic [3:0] n;
    n = (m == `LBSS_MODE_LAST) ? `LBSS_MODE_MEASURE : m + 4'h1;
    if (!pm && (n == `LBSS_MODE_START || n == `LBSS_MODE_FULL)) begin
        n = 4'h4;
    end
    return n;
endfunction

lbss_state_type state;
lbss_state_type next_state;
logic in_scale_mode;
logic commit;
logic leave_mode;

assign in_scale_mode = (mode_display == `LBSS_MODE_START) ||
                       (mode_display == `LBSS_MODE_FULL);
assign leave_mode = key_rise.mode || idle_expired;
assign commit = leave_mode && state != LBSS_ST_SHOW && !key_locked;

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        mode_display <= `LBSS_MODE_MEASURE;
    end else if (idle_expired) begin
        mode_display <= `LBSS_MODE_MEASURE;
    end else if (key_rise.mode) begin
        mode_display <= step_mode(mode_display, pressure_mode);
    end
end

////////////////////////////////////////////////////////////////////////////////
// limit window and shared divider

logic signed [39:0] lo40;
logic signed [39:0] hi40;
logic signed [39:0] margin;
logic signed [39:0] lo_ext;
logic signed [39:0] hi_ext;
logic signed [39:0] min_span;
logic signed [39:0] p40;
logic signed [39:0] ma40;
logic signed [39:0] me40;
logic signed [39:0] d40;
logic signed [39:0] num;
logic signed [39:0] den;
logic signed [39:0] quo;
logic signed [39:0] cand;
logic signed [39:0] cur_calc;
logic signed [15:0] edit_cur;
logic signed [15:0] good_cur;
logic signed [15:0] pending;

assign lo40 = 40'(limits.lower);
assign hi40 = 40'(limits.upper);
assign margin = (hi40 - lo40) / `LBSS_LIMIT_MARGIN_DIV;
assign lo_ext = lo40 - margin;
assign hi_ext = hi40 + margin;
assign min_span = (hi40 - lo40) / `LBSS_TURNDOWN_DIV;
assign p40 = 40'(pressure);
assign ma40 = 40'(start_of_scale);
assign me40 = 40'(full_scale);
assign d40 = 40'(edit_cur) - `LBSS_CUR_ZERO_UA;

// one divider serves both the derivation and the live current
always_comb begin
    num = (p40 - ma40) * `LBSS_CUR_SPAN_UA;
    den = me40 - ma40;
    if (state == LBSS_ST_ADJUST && mode_display == `LBSS_MODE_START) begin
        num = p40 * `LBSS_CUR_SPAN_UA - d40 * me40;
        den = `LBSS_CUR_SPAN_UA - d40;
    end else if (state == LBSS_ST_ADJUST && mode_display == `LBSS_MODE_FULL) begin
        num = (p40 - ma40) * `LBSS_CUR_SPAN_UA;
        den = d40;
    end
end

assign quo = (den == 40'sh0) ? 40'sh0 : num / den;
assign cand = (mode_display == `LBSS_MODE_FULL) ? quo + ma40 : quo;
assign cur_calc = quo + `LBSS_CUR_ZERO_UA;

// accepted if inside limits widened by a fifth and span not too small
function automatic logic fits(input logic signed [39:0] v, input logic is_full,
                              input logic signed [39:0] ma, input logic signed [39:0] me,
                              input logic signed [39:0] lo, input logic signed [39:0] hi,
                              input logic signed [39:0] ms);
    logic signed [39:0] span;
    span = is_full ? v - ma : me - v;
    if (span < 40'sh0) begin
        span = -span;
    end
    return (v >= lo) && (v <= hi) && (span >= ms) && (span != 40'sh0);
endfunction

logic cand_ok;
logic press_ok;
assign cand_ok = fits(cand, mode_display == `LBSS_MODE_FULL, ma40, me40,
                      lo_ext, hi_ext, min_span);
assign press_ok = fits(p40, mode_display == `LBSS_MODE_FULL, ma40, me40,
                       lo_ext, hi_ext, min_span);

////////////////////////////////////////////////////////////////////////////////
// editing state

always_comb begin
    next_state = state;
    if (leave_mode || !in_scale_mode || key_locked) begin
        next_state = LBSS_ST_SHOW;
    end else if (set_hold_done) begin
        next_state = press_ok ? LBSS_ST_SET : state;
    end else if ((key_rise.up ^ key_rise.down) && !both_arrows) begin
        next_state = LBSS_ST_ADJUST;
    end
end

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        state <= LBSS_ST_SHOW;
    end else begin
        state <= next_state;
    end
end

// edit current starts from the present output and falls back when out of range
always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        edit_cur <= `LBSS_CUR_RST;
        good_cur <= `LBSS_CUR_RST;
    end else if (state == LBSS_ST_ADJUST) begin
        if (key_rise.up && !key_sync.down) begin
            edit_cur <= edit_cur + `LBSS_CUR_STEP_UA;
        end else if (key_rise.down && !key_sync.up) begin
            edit_cur <= edit_cur - `LBSS_CUR_STEP_UA;
        end else if (cand_ok) begin
            good_cur <= edit_cur;
        end else begin
            edit_cur <= good_cur;
        end
    end else if (next_state == LBSS_ST_ADJUST) begin
        edit_cur <= 16'(out_current) + (key_rise.up ? `LBSS_CUR_STEP_UA : 16'h0000)
                    - (key_rise.down ? `LBSS_CUR_STEP_UA : 16'h0000);
        good_cur <= 16'(out_current);
    end
end

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        pending <= `LBSS_START_RST;
    end else if (state == LBSS_ST_SHOW && next_state == LBSS_ST_SET) begin
        pending <= pressure;
    end else if (state == LBSS_ST_SET && set_hold_done && press_ok) begin
        pending <= pressure;
    end else if (state == LBSS_ST_ADJUST && cand_ok) begin
        pending <= cand[15:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// stored scale values

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        start_of_scale <= `LBSS_START_RST;
    end else if (commit && mode_display == `LBSS_MODE_START) begin
        start_of_scale <= pending;
    end
end

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        full_scale <= `LBSS_FULL_RST;
    end else if (commit && mode_display == `LBSS_MODE_FULL) begin
        full_scale <= pending;
    end
end

////////////////////////////////////////////////////////////////////////////////
// output current and display

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        out_current <= `LBSS_CUR_RST;
    end else if (state == LBSS_ST_ADJUST) begin
        out_current <= 16'(edit_cur);
    end else if (cur_calc < `LBSS_CUR_MIN_UA) begin
        out_current <= 16'(`LBSS_CUR_MIN_UA);
    end else if (cur_calc > `LBSS_CUR_MAX_UA) begin
        out_current <= 16'(`LBSS_CUR_MAX_UA);
    end else begin
        out_current <= cur_calc[15:0];
    end
end

always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        value_display <= '0;
        editing <= 1'b0;
    end else begin
        editing <= (next_state != LBSS_ST_SHOW);
        if (mode_display == `LBSS_MODE_MEASURE) begin
            value_display <= pressure;
        end else if (state == LBSS_ST_SHOW) begin
            value_display <= (mode_display == `LBSS_MODE_FULL) ? full_scale : start_of_scale;
        end else begin
            value_display <= pending;
        end
    end
end

endmodule

/* File: verif/lbss_operator.sv */
// operator model pressing the three local buttons
module lbss_operator
    import lbss_pkg::*;
(
    input wire logic clk_sys,
    output lbss_keys_type keys_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial keys_pin = '0;
    // buttons released between presses so every press is a fresh rise
    task automatic press(input lbss_keys_type k, input int n);
        @(posedge clk_sys);
        keys_pin <= k;
        repeat (n) @(posedge clk_sys);
        keys_pin <= '0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

/* File: verif/lbss_top_sva.sv */
// assertions on the ports of the button scale setup block
module lbss_top_sva
    import lbss_pkg::*;
#(
    parameter logic [31:0] IDLE_CYC = 32'd200,
    parameter logic [31:0] UNLOCK_CYC = 32'd40
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire lbss_keys_type keys_pin,
    input wire logic pressure_mode,
    input wire logic [3:0] mode_display,
    input wire logic [15:0] out_current,
    input wire logic signed [15:0] start_of_scale,
    input wire logic signed [15:0] full_scale,
    input wire logic key_locked,
    input wire logic editing
);
    logic [31:0] idle;
    logic [31:0] held;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) idle <= '0;
        else idle <= (keys_pin == 3'h0) ? idle + 32'd1 : '0;
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) held <= '0;
        else held <= keys_pin.mode ? held + 32'd1 : '0;
    end
    sequence step_seen;
        $changed(mode_display) && mode_display != 4'h0;
    endsequence
    mode_cause_a: assert property (step_seen |-> $past(keys_pin.mode, 3))
        else $error("mode moved without a press");
    mode_next_a: assert property (step_seen |-> mode_display == $past(mode_display) + 4'h1
        || (!pressure_mode && $past(mode_display) == 4'h1 && mode_display == 4'h4))
        else $error("mode did not step to the next");
    mode_skip_a: assert property (step_seen and !pressure_mode
        |-> !(mode_display inside {4'h2, 4'h3}))
        else $error("scale mode entered outside pressure mode");
    mode_wrap_a: assert property ($changed(mode_display) && $past(mode_display) == 4'he
        |-> mode_display == 4'h0) else $error("no wrap after last mode");
    start_store_a: assert property ($changed(start_of_scale) |-> $past(mode_display) == 4'h2
        && !editing) else $error("start stored outside mode 2");
    full_store_a: assert property ($changed(full_scale) |-> $past(mode_display) == 4'h3
        && !editing) else $error("full stored outside mode 3");
    edit_mode_a: assert property (editing |-> mode_display inside {4'h2, 4'h3})
        else $error("editing outside scale modes");
    lock_hold_a: assert property (key_locked && $past(key_locked)
        |-> $stable(start_of_scale) && $stable(full_scale)) else $error("locked scale changed");
    current_clamp_a: assert property (out_current >= 16'h0e10 && out_current <= 16'h5208)
        else $error("current outside clamp");
    long_unlock_a: assert property (held > UNLOCK_CYC + 32'd8 |-> !key_locked)
        else $error("long mode hold kept lock");
    idle_home_a: assert property (idle > IDLE_CYC + 32'd8 |-> mode_display == 4'h0)
        else $error("idle time did not return home");
endmodule

bind lbss_top lbss_top_sva #(.IDLE_CYC(IDLE_CYC), .UNLOCK_CYC(UNLOCK_CYC)) u_lbss_top_sva (
    .clk_sys, .nrst, .keys_pin, .pressure_mode, .mode_display, .out_current,
    .start_of_scale, .full_scale, .key_locked, .editing);

/* File: verif/tb.sv */
// self-checking bench for the button scale setup block
module tb
    import lbss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic signed [15:0] p;
        logic [15:0] i;
    } lbss_row_type;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    lbss_keys_type keys_pin;
    logic signed [15:0] pressure = 16'sh0000;
    lbss_limits_type limits = '{16'sh0000, 16'sh3e80};
    logic pressure_mode = 1'b0;
    logic lock_request = 1'b0;
    logic [3:0] mode_display;
    logic signed [15:0] value_display;
    logic [15:0] out_current;
    logic signed [15:0] start_of_scale;
    logic signed [15:0] full_scale;
    logic key_locked;
    logic editing;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    // idle current with reset scale 0..16000, clamped at both ends
    lbss_row_type rows [5] = '{'{16'sh0000, 16'h0fa0}, '{16'sh1f40, 16'h2ee0},
        '{16'sh3e80, 16'h4e20}, '{-16'sh03e8, 16'h0e10}, '{16'sh4e20, 16'h5208}};

    lbss_operator u_lbss_operator (.clk_sys, .keys_pin);
    lbss_top #(.IDLE_CYC(32'd200), .SET_HOLD_CYC(32'd20), .UNLOCK_CYC(32'd40)) u_lbss_top (
        .clk_sys, .nrst, .keys_pin, .pressure, .limits, .pressure_mode, .lock_request,
        .mode_display, .value_display, .out_current, .start_of_scale, .full_scale,
        .key_locked, .editing);

    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic go_mode(input logic [3:0] m);
        for (int n = 0; n < 16 && mode_display !== m; n++) begin
            u_lbss_operator.press(3'b100, 6);
        end
    endtask

    // hold both arrows past the set time, then store with mode
    task automatic set_scale(input logic signed [15:0] p);
        @(posedge clk_sys);
        pressure <= p;
        u_lbss_operator.press(3'b011, 30);
        u_lbss_operator.press(3'b100, 6);
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            report_and_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk_sys);
        check({12'h000, mode_display}, 16'h0000);
        check(start_of_scale, 16'h0000);
        check(full_scale, 16'h3e80);
        check(out_current, 16'h0fa0);
        @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (rows[k]) begin
            @(posedge clk_sys);
            pressure <= rows[k].p;
            repeat (8) @(negedge clk_sys);
            check(out_current, rows[k].i);
        end
        check(value_display, 16'h4e20);
        go_mode(4'h4);
        check({12'h000, mode_display}, 16'h0004);
        go_mode(4'h0);
        check({12'h000, mode_display}, 16'h0000);
        @(posedge clk_sys);
        pressure_mode <= 1'b1;
        go_mode(4'h2);
        check({12'h000, mode_display}, 16'h0002);
        set_scale(16'sh07d0);
        check(start_of_scale, 16'h07d0);
        check({12'h000, mode_display}, 16'h0003);
        set_scale(16'sh36b0);
        check(full_scale, 16'h36b0);
        @(posedge clk_sys);
        pressure <= 16'sh1f40;
        repeat (8) @(posedge clk_sys);
        check(out_current, 16'h2ee0);
        go_mode(4'h2);
        set_scale(-16'sh1388);
        check(start_of_scale, 16'h07d0);
        set_scale(16'sh03e8);
        check(full_scale, 16'h03e8);
        @(posedge clk_sys);
        lock_request <= 1'b1;
        @(posedge clk_sys);
        lock_request <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({15'h0000, key_locked}, 16'h0001);
        go_mode(4'h2);
        set_scale(16'sh0bb8);
        check(start_of_scale, 16'h07d0);
        u_lbss_operator.press(3'b100, 60);
        check({15'h0000, key_locked}, 16'h0000);
        @(posedge clk_sys);
        pressure <= 16'sh05dc;
        go_mode(4'h2);
        u_lbss_operator.press(3'b010, 6);
        check(out_current, 16'h2eea);
        u_lbss_operator.press(3'b001, 6);
        u_lbss_operator.press(3'b001, 6);
        check(out_current, 16'h2ed6);
        check(value_display, 16'h07ce);
        check({15'h0000, editing}, 16'h0001);
        u_lbss_operator.press(3'b100, 6);
        check(start_of_scale, 16'h07ce);
        repeat (230) @(posedge clk_sys);
        check({12'h000, mode_display}, 16'h0000);
        // span of 50 against start 1998 is under a hundredth of the limits
        go_mode(4'h3);
        set_scale(16'sh0800);
        check(full_scale, 16'h03e8);
        report_and_stop;
    end
endmodule
